// ===== core/dcs_top.sv
// daisy chain serial slave: core-clock control and diagnosis registers
//
// Overview of operation
// RL1 - one shift register, one bit per clock
// RL2 - a device frame is eight serial clocks
// RL3 - data accepted only on chip-select rise
// RL4 - displaced bits feed the next chained device
// RL5 - master shifts N times eight bits
// RL6 - chip select high at least 300 ns
// RL7 - 200 us gap gives valid diagnosis
// RL8 - control and diagnosis register groups
// RL9 - power-on reset loads register defaults
// RL10 - sample falling edge, drive rising, msb first
// RL11 - chip-select fall loads diagnosis word
// RL12 - chip-select rise copies data, clears flags
// RL13 - chip select high: ignore clock, float output
`timescale 1ns/10ps
`default_nettype none
module dcs_top #(
  parameter int unsigned FAULT_CYC = dcs_pkg::FAULT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [dcs_pkg::FRAME_W-1:0] fault_i,
  output logic [dcs_pkg::FRAME_W-1:0] ctrl_o,
  output logic ctrl_stb_o,
  output logic [dcs_pkg::FRAME_W-1:0] diag_o,
  output logic frame_err_o,
  output logic gap_short_o,
  output logic diag_stale_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // serial clock side
  // ----------------------------------------------------------------
  dcs_link_if link ();

  dcs_shifter u_shifter (
    .sclk_i(sclk_i),
    .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .link(link)
  );

  // ----------------------------------------------------------------
  // crossings into the core clock
  // ----------------------------------------------------------------
  logic [1:0] sync_in;
  logic [1:0] sync_out;
  logic cs_s;
  logic tgl_s;

  // select travels active high so the synchroniser's reset value means idle;
  // otherwise every reset would be followed by a false select edge
  assign sync_in = {~cs_n_i, link.tgl};

  dcs_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(sync_in),
    .q_o(sync_out)
  );
  assign cs_s = ~sync_out[1];
  assign tgl_s = sync_out[0];

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_d;
    logic tgl_ref;
    logic [dcs_pkg::FRAME_W-1:0] ctrl;
    logic [dcs_pkg::FRAME_W-1:0] diag;
    logic [dcs_pkg::FRAME_W-1:0] snap;
    logic [dcs_pkg::GAP_W-1:0] gap;
    logic stb;
    logic ferr;
    logic gshort;
    logic stale;
  } dcs_core_t;

  dcs_core_t st_q;
  dcs_core_t st_d;
  logic cs_rise;
  logic cs_fall;
  logic clocked;
  logic frame_ok;
  logic [dcs_pkg::GAP_W-1:0] fault_lim;

  assign cs_rise = cs_s && !st_q.cs_d;
  assign cs_fall = !cs_s && st_q.cs_d;
  // a toggle change since the fall means at least one serial clock came
  assign clocked = tgl_s != st_q.tgl_ref;
  // sr and cnt are quiet here: the serial clock stopped well before the rise
  assign frame_ok = clocked && (link.cnt == dcs_pkg::CNT_ZERO); // RL2
  assign fault_lim = dcs_pkg::GAP_W'(FAULT_CYC);

  always_comb begin
    st_d = st_q;
    st_d.cs_d = cs_s;
    st_d.stb = 1'b0;

    // gap counter runs only while chip select is high
    if (cs_s) begin
      if (st_q.gap != dcs_pkg::GAP_MAX) begin
        st_d.gap = st_q.gap + dcs_pkg::GAP_ONE;
      end
    end

    // access start: freeze diagnosis for the outgoing word
    if (cs_fall) begin
      st_d.snap = st_q.diag; // RL11
      st_d.tgl_ref = tgl_s;
      st_d.gshort = st_q.gap < dcs_pkg::DT_CYC; // RL6
      st_d.stale = st_q.gap < fault_lim; // RL7
    end

    // access end: accept only whole frames
    if (cs_rise) begin
      st_d.gap = '0;
      if (frame_ok) begin
        st_d.ctrl = link.sr; // RL3
        st_d.stb = 1'b1;
        st_d.ferr = 1'b0;
        st_d.diag = dcs_pkg::DIAG_RST; // RL12
      end else begin
        st_d.ferr = 1'b1;
      end
    end

    // a fault in the clearing cycle survives
    st_d.diag = st_d.diag | fault_i; // RL12
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{
        cs_d: 1'b1,
        tgl_ref: 1'b0,
        ctrl: dcs_pkg::CTRL_RST, // RL9
        diag: dcs_pkg::DIAG_RST, // RL9
        snap: dcs_pkg::DIAG_RST,
        gap: dcs_pkg::GAP_MAX,
        stb: 1'b0,
        ferr: 1'b0,
        gshort: 1'b0,
        stale: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs: control group and diagnosis group
  // ----------------------------------------------------------------
  assign link.snap = st_q.snap;
  assign ctrl_o = st_q.ctrl; // RL8
  assign diag_o = st_q.diag; // RL8
  assign ctrl_stb_o = st_q.stb;
  assign frame_err_o = st_q.ferr;
  assign gap_short_o = st_q.gshort;
  assign diag_stale_o = st_q.stale;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence good_end_s;
    cs_rise && frame_ok;
  endsequence
  sequence bad_end_s;
    cs_rise && !frame_ok;
  endsequence

  accept_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL3
    good_end_s |=> ctrl_o == $past(link.sr) && ctrl_stb_o)
    else $error("accepted word not copied to control register");
  ctrl_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL3
    !cs_rise |=> $stable(ctrl_o) && !ctrl_stb_o)
    else $error("control register changed without chip-select rise");
  bad_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL2
    bad_end_s |=> $stable(ctrl_o) && frame_err_o)
    else $error("partial frame was accepted");
  diag_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL12
    good_end_s |=> diag_o == $past(fault_i))
    else $error("diagnosis flags not cleared on accept");
  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL12
    fault_i != dcs_pkg::DIAG_RST |=> (diag_o & $past(fault_i)) == $past(fault_i))
    else $error("fault event lost");
  snap_load_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL11
    cs_fall |=> link.snap == $past(diag_o))
    else $error("diagnosis not frozen at chip-select fall");
  float_out_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL13
    cs_n_i |-> !so_oe_o)
    else $error("serial output driven while deselected");
  reset_dflt_a: assert property (@(posedge clk_i) // RL9
    $rose(rst_n) |-> ctrl_o == dcs_pkg::CTRL_RST && diag_o == dcs_pkg::DIAG_RST)
    else $error("registers not at default after reset");
  gap_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    cs_fall && st_q.gap < dcs_pkg::DT_CYC |=> gap_short_o)
    else $error("short chip-select gap not flagged");

  // ----------------------------------------------------------------
  // checks: strobe and frame error bookkeeping
  // ----------------------------------------------------------------
  stb_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL3
    ctrl_stb_o |=> !ctrl_stb_o)
    else $error("control strobe longer than one cycle");

  stb_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL3
    ctrl_stb_o |-> $past(cs_rise && frame_ok))
    else $error("control strobe without an accepted frame");

  ferr_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL2
    good_end_s |=> !frame_err_o)
    else $error("frame error not cleared by a whole frame");

  ferr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL2
    !cs_rise |=> $stable(frame_err_o))
    else $error("frame error changed between accesses");

  reset_flags_a: assert property (@(posedge clk_i) // RL9
    $rose(rst_n) |-> !frame_err_o && !gap_short_o && !diag_stale_o && !ctrl_stb_o)
    else $error("status flags not clear after reset");

  // ----------------------------------------------------------------
  // checks: chip-select gap monitor
  // ----------------------------------------------------------------
  gap_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    cs_rise |=> st_q.gap == '0)
    else $error("gap counter not restarted at chip-select rise");

  gap_count_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    cs_s && !cs_rise && st_q.gap != dcs_pkg::GAP_MAX |=>
      st_q.gap == $past(st_q.gap) + dcs_pkg::GAP_ONE)
    else $error("gap counter did not advance while deselected");

  gap_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    !cs_s |=> $stable(st_q.gap))
    else $error("gap counter moved during an access");

  gap_ok_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    cs_fall && st_q.gap >= dcs_pkg::DT_CYC |=> !gap_short_o)
    else $error("long enough gap flagged short");

  stale_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL7
    cs_fall && st_q.gap < fault_lim |=> diag_stale_o)
    else $error("gap below fault delay not flagged");

  stale_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL7
    cs_fall && st_q.gap >= fault_lim |=> !diag_stale_o)
    else $error("gap above fault delay flagged stale");

  flags_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    !cs_fall |=> $stable(gap_short_o) && $stable(diag_stale_o))
    else $error("gap flags changed outside chip-select fall");

  // ----------------------------------------------------------------
  // checks: diagnosis group and clock toggle reference
  // ----------------------------------------------------------------
  keep_diag_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL12
    bad_end_s |=> (diag_o & $past(diag_o)) == $past(diag_o))
    else $error("refused frame cleared diagnosis flags");

  diag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL12
    !(cs_rise && frame_ok) && fault_i == dcs_pkg::DIAG_RST |=> $stable(diag_o))
    else $error("diagnosis changed with no fault and no accept");

  snap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL11
    !cs_fall |=> $stable(link.snap))
    else $error("outgoing diagnosis word changed during access");

  sequence open_s;
    cs_fall;
  endsequence

  tgl_ref_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL2
    open_s |=> st_q.tgl_ref == $past(tgl_s))
    else $error("clock toggle reference not taken at chip-select fall");
endmodule : dcs_top
`default_nettype wire

// ===== inc/dcs_pkg.sv
// constants shared by the daisy chain serial slave core and shifter
package dcs_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_W = 8;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam int unsigned MSB = FRAME_W - 1;

  // ----------------------------------------------------------------
  // register defaults after power-on reset
  // ----------------------------------------------------------------
  localparam logic [FRAME_W-1:0] CTRL_RST = 8'h00;
  localparam logic [FRAME_W-1:0] DIAG_RST = 8'h00;
  localparam logic [FRAME_W-1:0] SR_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: core clock and chip-select gap figures
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_DT_NS = 300;
  localparam int unsigned T_FAULT_US = 200;
  localparam int unsigned GAP_W = 15;
  // least time: round up
  localparam logic [GAP_W-1:0] DT_CYC =
    GAP_W'((T_DT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned FAULT_CYC_DEF = (T_FAULT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [GAP_W-1:0] GAP_MAX = 15'h7fff;
  localparam logic [GAP_W-1:0] GAP_ONE = 15'h0001;
endpackage : dcs_pkg

// ===== inc/dcs_link_if.sv
// carrier between the core-clock logic and the serial-clock shifter
`timescale 1ns/10ps
`default_nettype none
interface dcs_link_if;
  logic [dcs_pkg::FRAME_W-1:0] sr;
  logic [dcs_pkg::CNT_W-1:0] cnt;
  logic tgl;
  logic [dcs_pkg::FRAME_W-1:0] snap;
  modport core (input sr, input cnt, input tgl, output snap);
  modport shift (output sr, output cnt, output tgl, input snap);
endinterface : dcs_link_if
`default_nettype wire

// ===== core/dcs_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module dcs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dcs_sync_t;

  dcs_sync_t st_q;
  dcs_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.s2;
endmodule : dcs_sync
`default_nettype wire

// ===== core/dcs_shifter.sv
// serial-clock side: shift register, bit count and serial output
`timescale 1ns/10ps
`default_nettype none
module dcs_shifter (
  input wire logic sclk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  dcs_link_if.shift link
);
  // two clock edges, so two state words
  typedef struct packed {
    logic [dcs_pkg::FRAME_W-1:0] sr;
    logic [dcs_pkg::CNT_W-1:0] cnt;
    logic tgl;
  } dcs_fall_t;
  typedef struct packed {
    logic so;
  } dcs_rise_t;

  dcs_fall_t fall_q;
  dcs_fall_t fall_d;
  dcs_rise_t rise_q;
  dcs_rise_t rise_d;
  logic first_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    fall_d = fall_q;
    rise_d = rise_q;
    if (!cs_n_i) begin // RL13
      if (first_q) begin
        fall_d.sr = {link.snap[dcs_pkg::MSB-1:0], si_i}; // RL11
        fall_d.cnt = dcs_pkg::CNT_ONE;
        fall_d.tgl = ~fall_q.tgl;
      end else begin
        fall_d.sr = {fall_q.sr[dcs_pkg::MSB-1:0], si_i}; // RL1
        fall_d.cnt = fall_q.cnt + dcs_pkg::CNT_ONE; // RL2
      end
      // displaced bit leaves msb first, feeding the next device
      rise_d.so = first_q ? link.snap[dcs_pkg::MSB] : fall_q.sr[dcs_pkg::MSB]; // RL4
    end
  end

  // capture on the falling serial edge
  always_ff @(negedge sclk_i or negedge arst_n_i) begin // RL10
    if (!arst_n_i) begin
      fall_q <= '{sr: dcs_pkg::SR_RST, cnt: dcs_pkg::CNT_ZERO, tgl: 1'b0};
    end else begin
      fall_q <= fall_d;
    end
  end

  // launch on the rising serial edge
  always_ff @(posedge sclk_i or negedge arst_n_i) begin // RL10
    if (!arst_n_i) begin
      rise_q <= '0;
    end else begin
      rise_q <= rise_d;
    end
  end

  // sr is not cleared by chip select: the core copies it after the rise
  always_ff @(negedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
    if (!arst_n_i || cs_n_i) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign link.sr = fall_q.sr;
  assign link.cnt = fall_q.cnt;
  assign link.tgl = fall_q.tgl;
  assign so_o = rise_q.so;
  assign so_oe_o = ~cs_n_i; // RL13

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence frame_start_s;
    first_q && !cs_n_i;
  endsequence
  sequence eight_falls_s;
    ##8 (fall_q.cnt == dcs_pkg::CNT_ZERO);
  endsequence

  shift_in_a: assert property (@(negedge sclk_i) disable iff (cs_n_i || !arst_n_i) // RL1
    !first_q |=> fall_q.sr == {$past(fall_q.sr[dcs_pkg::MSB-1:0]), $past(si_i)})
    else $error("shift register did not take si");
  diag_load_a: assert property (@(negedge sclk_i) disable iff (cs_n_i || !arst_n_i) // RL11
    frame_start_s |=> fall_q.sr[dcs_pkg::MSB:1] == $past(link.snap[dcs_pkg::MSB-1:0]))
    else $error("diagnosis word not loaded at frame start");
  frame_len_a: assert property (@(negedge sclk_i) disable iff (cs_n_i || !arst_n_i) // RL2
    frame_start_s |-> eight_falls_s)
    else $error("bit count not back to zero after eight clocks");
  so_chain_a: assert property (@(posedge sclk_i) disable iff (cs_n_i || !arst_n_i) // RL4
    !first_q |=> so_o == $past(fall_q.sr[dcs_pkg::MSB]))
    else $error("serial output is not the displaced bit");
endmodule : dcs_shifter
`default_nettype wire

// ===== sim/dcs_master.sv
// serial master model driving frames into the slave, standing in for the controller
`timescale 1ns/10ps
`default_nettype none
module dcs_master (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  // ----------------------------------------------------------------
  // idle levels: clock still and low, select pulled up, data pulled down
  // ----------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // one access of n bits, msb first; leaves select high on return
  // ----------------------------------------------------------------
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    #3;
    cs_n_o = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      si_o = tx[i];
      #80;
      rx = {rx[14:0], so_i};
      sclk_o = 1'b0;
      #80;
    end
    // lag before release; sclk already low at the select edge
    #200;
    si_o = 1'b0;
    cs_n_o = 1'b1;
  endtask : xfer

  // ----------------------------------------------------------------
  // clock and data activity with select high; n even leaves both low
  // ----------------------------------------------------------------
  task automatic idle_toggle(input int n);
    for (int i = 0; i < n; i++) begin
      #80;
      sclk_o = ~sclk_o;
      si_o = ~si_o;
    end
  endtask : idle_toggle
endmodule : dcs_master
`default_nettype wire

// ===== sim/dcs_top_test.sv
// self-checking testbench for the daisy chain serial slave
`timescale 1ns/10ps
`default_nettype none
module dcs_top_test;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_w;
  logic [7:0] fault = 8'h00;
  logic [7:0] ctrl;
  logic [7:0] diag;
  logic stb;
  logic ferr;
  logic gshort;
  logic dstale;
  logic [15:0] rx;
  int errors = 0;
  int num_checks = 0;

  always #4 clk_i = ~clk_i;
  assign so_w = so_oe ? so : 1'bz;

  dcs_top #(.FAULT_CYC(50)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .fault_i(fault), .ctrl_o(ctrl), .ctrl_stb_o(stb),
    .diag_o(diag), .frame_err_o(ferr), .gap_short_o(gshort), .diag_stale_o(dstale)
  );

  dcs_master master (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // strobe lasts one cycle, so look at every falling clk edge
  task automatic wait_stb;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (stb === 1'b1) begin
        return;
      end
    end
    errors++;
    test_done();
  endtask : wait_stb

  task automatic frame(input int n, input logic [15:0] tx);
    master.xfer(n, tx, rx);
    wait_stb();
    #600;
  endtask : frame

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({ctrl, diag}, 16'h0000);
    check({13'h0, ferr, gshort, dstale}, 16'h0000);
    check({15'h0, so_oe}, 16'h0000);
  endtask : t_reset

  task automatic t_single;
    master.xfer(8, 16'h00a5, rx);
    check({8'h00, ctrl}, 16'h0000);
    wait_stb();
    check({8'h00, ctrl}, 16'h00a5);
    #600;
  endtask : t_single

  task automatic t_diag;
    @(posedge clk_i);
    #1 fault = 8'h42;
    @(posedge clk_i);
    #1 fault = 8'h00;
    repeat (3) @(posedge clk_i);
    check({8'h00, diag}, 16'h0042);
    frame(8, 16'h0011);
    check({8'h00, rx[7:0]}, 16'h0042);
    check({ctrl, diag}, 16'h1100);
  endtask : t_diag

  task automatic t_chain;
    frame(16, 16'h3cc3);
    check(rx, 16'h003c);
    check({8'h00, ctrl}, 16'h00c3);
  endtask : t_chain

  task automatic t_short;
    master.xfer(5, 16'h001f, rx);
    repeat (10) @(posedge clk_i);
    check({7'h00, ferr, ctrl}, 16'h01c3);
    #600;
  endtask : t_short

  task automatic t_idle;
    master.idle_toggle(8);
    #100;
    check({7'h00, so_oe, ctrl}, 16'h00c3);
    frame(8, 16'h005a);
    check({7'h00, ferr, ctrl}, 16'h005a);
    // select low with no clock at all is refused as well
    master.xfer(0, 16'h0000, rx);
    repeat (10) @(posedge clk_i);
    check({7'h00, ferr, ctrl}, 16'h015a);
    #600;
  endtask : t_idle

  task automatic t_gap;
    master.xfer(8, 16'h0077, rx);
    wait_stb();
    #100;
    frame(8, 16'h0066);
    check({14'h0, gshort, dstale}, 16'h0003);
    frame(8, 16'h0055);
    check({6'h00, gshort, dstale, ctrl}, 16'h0055);
  endtask : t_gap

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 t_reset();
    t_single();
    t_diag();
    t_chain();
    t_short();
    t_idle();
    t_gap();
    test_done();
  end
endmodule : dcs_top_test
`default_nettype wire
